// ===== pkg/tci_pkg.sv
package tci_pkg;

  // Register bus geometry.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SRC_N  = 8;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_SET    = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_CLEAR  = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_STATE  = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_MODE   = 8'h30;

  // Source bit positions, shared by status, set, clear and state registers; BIT_WAVE_MODE is the mode register bit.
  localparam int unsigned BIT_OVERFLOW  = 0;
  localparam int unsigned BIT_LOAD_OVR  = 1;
  localparam int unsigned BIT_CMP_A     = 2;
  localparam int unsigned BIT_CMP_B     = 3;
  localparam int unsigned BIT_CMP_C     = 4;
  localparam int unsigned BIT_CAP_A     = 5;
  localparam int unsigned BIT_CAP_B     = 6;
  localparam int unsigned BIT_EXT_TRIG  = 7;
  localparam int unsigned BIT_WAVE_MODE = 0;

  // Sources that only act in capture mode or only in waveform mode.
  localparam logic [SRC_N-1:0] CAPTURE_ONLY = 8'h62;
  localparam logic [SRC_N-1:0] WAVE_ONLY    = 8'h0c;

  // Values after reset.
  localparam logic [SRC_N-1:0] MASK_RST   = 8'h00;
  localparam logic [SRC_N-1:0] STATUS_RST = 8'h00;
  localparam logic             WAVE_RST   = 1'b0;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Event flags from the counter, one pulse or level per source.
  typedef struct packed {
    logic ext_trigger_event;
    logic capture_b_load_event;
    logic capture_a_load_event;
    logic compare_c_event;
    logic compare_b_event;
    logic compare_a_event;
    logic load_overrun_event;
    logic overflow_event;
  } tci_evt_t;

  typedef enum logic {WR_IDLE, WR_RESP} tci_wr_state_t;
  typedef enum logic {RD_IDLE, RD_DATA} tci_rd_state_t;

endpackage

// ===== rtl/tci_irq_mask.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns

// Operation
// - Set register writes ones into mask
// - Clear register writes ones clear mask
// - State register reads current mask bits
// - Bit1 load overrun, clear in capture
// - Bit2 compare A, clear in waveform
// - Bit3 compare B, clear in waveform
// - Bit4 compare C, any mode
// - Bit5 capture A load, clear in capture
// - Bit6 capture B load, clear in capture
// - Bit7 external trigger, bit0 overflow, unconditional
// - Status flags sticky, cleared by status read
// - Waveform select gates mode-qualified sources
module tci_irq_mask (
  // Clock and reset.
  input  wire logic                          clk_i,
  input  wire logic                          srst_i,
  // Events from the counter channel.
  input  wire tci_pkg::tci_evt_t             evt_i,
  // AXI4-Lite write address and data.
  input  wire logic                          s_axi_awvalid_i,
  output logic                               s_axi_awready_o,
  input  wire logic [tci_pkg::ADDR_W-1:0]    s_axi_awaddr_i,
  input  wire logic                          s_axi_wvalid_i,
  output logic                               s_axi_wready_o,
  input  wire logic [tci_pkg::DATA_W-1:0]    s_axi_wdata_i,
  input  wire logic [tci_pkg::DATA_W/8-1:0]  s_axi_wstrb_i,
  // AXI4-Lite write response.
  output logic                               s_axi_bvalid_o,
  input  wire logic                          s_axi_bready_i,
  output logic [1:0]                         s_axi_bresp_o,
  // AXI4-Lite read.
  input  wire logic                          s_axi_arvalid_i,
  output logic                               s_axi_arready_o,
  input  wire logic [tci_pkg::ADDR_W-1:0]    s_axi_araddr_i,
  output logic                               s_axi_rvalid_o,
  input  wire logic                          s_axi_rready_i,
  output logic [tci_pkg::DATA_W-1:0]         s_axi_rdata_o,
  output logic [1:0]                         s_axi_rresp_o,
  // Channel interrupt and mode indication.
  output logic                               irq_o,
  output logic                               wave_mode_o
);
  import tci_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel.

  tci_wr_state_t             wr_state_ff, nxt_wr_state;
  logic                      aw_hold_ff, nxt_aw_hold;
  logic                      w_hold_ff, nxt_w_hold;
  logic [ADDR_W-1:0]         awaddr_ff, nxt_awaddr;
  logic [DATA_W-1:0]         wdata_ff, nxt_wdata;
  logic [DATA_W/8-1:0]       wstrb_ff, nxt_wstrb;
  logic                      awready_ff, nxt_awready;
  logic                      wready_ff, nxt_wready;
  logic                      bvalid_ff, nxt_bvalid;
  logic [1:0]                bresp_ff, nxt_bresp;
  logic                      wr_do;
  logic                      wr_hit;
  logic [SRC_N-1:0]          wr_byte;

  // Address and data are held separately so they may arrive in either order.
  assign wr_do   = aw_hold_ff & w_hold_ff & (wr_state_ff == WR_IDLE);
  // Only byte lane 0 carries defined bits; upper lanes are reserved.
  assign wr_byte = wstrb_ff[0] ? wdata_ff[SRC_N-1:0] : '0;

  // Decode of the write address.
  always_comb begin
    case (awaddr_ff)
      OFF_STATUS, OFF_SET, OFF_CLEAR, OFF_STATE, OFF_MODE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Next values of the write channel.
  always_comb begin
    nxt_aw_hold  = aw_hold_ff | (s_axi_awvalid_i & awready_ff);
    nxt_w_hold   = w_hold_ff | (s_axi_wvalid_i & wready_ff);
    nxt_awaddr   = (s_axi_awvalid_i & awready_ff) ? s_axi_awaddr_i : awaddr_ff;
    nxt_wdata    = (s_axi_wvalid_i & wready_ff) ? s_axi_wdata_i : wdata_ff;
    nxt_wstrb    = (s_axi_wvalid_i & wready_ff) ? s_axi_wstrb_i : wstrb_ff;
    nxt_wr_state = wr_state_ff;
    nxt_bvalid   = bvalid_ff;
    nxt_bresp    = bresp_ff;
    case (wr_state_ff)
      WR_IDLE: begin
        if (wr_do) begin
          nxt_aw_hold  = 1'b0;
          nxt_w_hold   = 1'b0;
          nxt_bvalid   = 1'b1;
          nxt_bresp    = wr_hit ? RESP_OKAY : RESP_SLVERR;
          nxt_wr_state = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready_i) begin
          nxt_bvalid   = 1'b0;
          nxt_wr_state = WR_IDLE;
        end
      end
      default: nxt_wr_state = WR_IDLE;
    endcase
    nxt_awready = ~nxt_aw_hold;
    nxt_wready  = ~nxt_w_hold;
  end

  // Registers of the write channel.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_state_ff <= WR_IDLE;
      aw_hold_ff  <= 1'b0;
      w_hold_ff   <= 1'b0;
      awaddr_ff   <= '0;
      wdata_ff    <= '0;
      wstrb_ff    <= '0;
      awready_ff  <= 1'b0;
      wready_ff   <= 1'b0;
      bvalid_ff   <= 1'b0;
      bresp_ff    <= RESP_OKAY;
    end else begin
      wr_state_ff <= nxt_wr_state;
      aw_hold_ff  <= nxt_aw_hold;
      w_hold_ff   <= nxt_w_hold;
      awaddr_ff   <= nxt_awaddr;
      wdata_ff    <= nxt_wdata;
      wstrb_ff    <= nxt_wstrb;
      awready_ff  <= nxt_awready;
      wready_ff   <= nxt_wready;
      bvalid_ff   <= nxt_bvalid;
      bresp_ff    <= nxt_bresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel.

  tci_rd_state_t             rd_state_ff, nxt_rd_state;
  logic                      arready_ff, nxt_arready;
  logic                      rvalid_ff, nxt_rvalid;
  logic [DATA_W-1:0]         rdata_ff, nxt_rdata;
  logic [1:0]                rresp_ff, nxt_rresp;
  logic                      rd_do;
  logic                      rd_status;
  logic [SRC_N-1:0]          status_ff, nxt_status;
  logic [SRC_N-1:0]          mask_ff, nxt_mask;
  logic                      wave_ff, nxt_wave;

  assign rd_do     = s_axi_arvalid_i & arready_ff;
  // A status read clears flags in the same edge that captures them.
  assign rd_status = rd_do & (s_axi_araddr_i == OFF_STATUS);

  // Next values of the read channel; one address at a time.
  always_comb begin
    nxt_rd_state = rd_state_ff;
    nxt_arready  = arready_ff;
    nxt_rvalid   = rvalid_ff;
    nxt_rdata    = rdata_ff;
    nxt_rresp    = rresp_ff;
    case (rd_state_ff)
      RD_IDLE: begin
        nxt_arready = 1'b1;
        if (rd_do) begin
          nxt_arready  = 1'b0;
          nxt_rvalid   = 1'b1;
          nxt_rresp    = RESP_OKAY;
          nxt_rd_state = RD_DATA;
          case (s_axi_araddr_i)
            OFF_STATUS: nxt_rdata = {24'h0, status_ff};
            OFF_STATE:  nxt_rdata = {24'h0, mask_ff};
            OFF_MODE:   nxt_rdata = {31'h0, wave_ff};
            OFF_SET, OFF_CLEAR: nxt_rdata = '0;
            default: begin
              nxt_rdata = '0;
              nxt_rresp = RESP_SLVERR;
            end
          endcase
        end
      end
      RD_DATA: begin
        if (s_axi_rready_i) begin
          nxt_rvalid   = 1'b0;
          nxt_arready  = 1'b1;
          nxt_rd_state = RD_IDLE;
        end
      end
      default: nxt_rd_state = RD_IDLE;
    endcase
  end

  // Registers of the read channel.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_state_ff <= RD_IDLE;
      arready_ff  <= 1'b0;
      rvalid_ff   <= 1'b0;
      rdata_ff    <= '0;
      rresp_ff    <= RESP_OKAY;
    end else begin
      rd_state_ff <= nxt_rd_state;
      arready_ff  <= nxt_arready;
      rvalid_ff   <= nxt_rvalid;
      rdata_ff    <= nxt_rdata;
      rresp_ff    <= nxt_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode, status flags, mask and interrupt.

  logic [SRC_N-1:0]          mode_ok;
  logic [SRC_N-1:0]          evt_ok;
  logic [SRC_N-1:0]          set_bits;
  logic [SRC_N-1:0]          clr_bits;
  logic [SRC_N-1:0]          st_clr;
  logic                      irq_ff, nxt_irq;

  // Sources that apply in the present mode; the rest are held off.
  assign mode_ok = wave_ff ? ~CAPTURE_ONLY : ~WAVE_ONLY;
  assign evt_ok  = evt_i & mode_ok;

  // Next values of the control and flag state.
  always_comb begin
    set_bits = (wr_do && awaddr_ff == OFF_SET) ? wr_byte : '0;
    // A clear of a mode-qualified bit only acts in its own mode.
    clr_bits = (wr_do && awaddr_ff == OFF_CLEAR) ? (wr_byte & mode_ok) : '0;
    st_clr   = (wr_do && awaddr_ff == OFF_STATUS) ? wr_byte : '0;
    if (rd_status) begin
      st_clr = '1;
    end
    // Events win over a clear in the same cycle so none is lost.
    nxt_status = (status_ff & ~st_clr) | evt_ok;
    nxt_mask   = (mask_ff | set_bits) & ~clr_bits;
    nxt_wave   = wave_ff;
    if (wr_do && awaddr_ff == OFF_MODE && wstrb_ff[0]) begin
      nxt_wave = wdata_ff[BIT_WAVE_MODE];
    end
    // Computed from the next state so the line tracks the flags exactly.
    nxt_irq = |(nxt_status & nxt_mask);
  end

  // Registers of the control and flag state.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_ff <= STATUS_RST;
      mask_ff   <= MASK_RST;
      wave_ff   <= WAVE_RST;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      mask_ff   <= nxt_mask;
      wave_ff   <= nxt_wave;
      irq_ff    <= nxt_irq;
    end
  end

  // Outputs, all straight from flip-flops.
  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o  = wready_ff;
  assign s_axi_bvalid_o  = bvalid_ff;
  assign s_axi_bresp_o   = bresp_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_rvalid_o  = rvalid_ff;
  assign s_axi_rdata_o   = rdata_ff;
  assign s_axi_rresp_o   = rresp_ff;
  assign irq_o           = irq_ff;
  assign wave_mode_o     = wave_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  logic wr_set, wr_clr;
  assign wr_set = wr_do & (awaddr_ff == OFF_SET) & wstrb_ff[0];
  assign wr_clr = wr_do & (awaddr_ff == OFF_CLEAR) & wstrb_ff[0];

  sequence s_state_read;
    rd_do && s_axi_araddr_i == OFF_STATE;
  endsequence

  sequence s_status_read;
    rd_do && s_axi_araddr_i == OFF_STATUS && evt_ok == '0;
  endsequence

  a_set_mask_bits: assert property (
    wr_set && !wr_clr |=> mask_ff == ($past(mask_ff) | $past(wdata_ff[SRC_N-1:0])))
    else $error("Set write did not raise the written mask bits.");

  a_clear_mask_bits: assert property (
    wr_clr |=> (mask_ff & $past(wdata_ff[SRC_N-1:0]) & $past(mode_ok)) == '0)
    else $error("Clear write left a written mask bit set.");

  a_state_read_value: assert property (
    s_state_read |=> rvalid_ff && s_axi_rdata_o == {24'h0, $past(mask_ff)})
    else $error("State read returned the wrong mask.");

  a_overrun_clear_mode: assert property (
    wr_clr && wave_ff && mask_ff[BIT_LOAD_OVR] |=> mask_ff[BIT_LOAD_OVR])
    else $error("Load overrun enable cleared in waveform mode.");

  a_cmp_a_clear_mode: assert property (
    wr_clr && !wave_ff && mask_ff[BIT_CMP_A] |=> mask_ff[BIT_CMP_A])
    else $error("Compare A enable cleared in capture mode.");

  a_cmp_b_clear_mode: assert property (
    wr_clr && !wave_ff && mask_ff[BIT_CMP_B] |=> mask_ff[BIT_CMP_B])
    else $error("Compare B enable cleared in capture mode.");

  a_cmp_c_any_mode: assert property (
    wr_clr && wdata_ff[BIT_CMP_C] && !wr_set |=> !mask_ff[BIT_CMP_C])
    else $error("Compare C enable not cleared.");

  a_cap_a_clear_mode: assert property (
    wr_clr && wave_ff && mask_ff[BIT_CAP_A] |=> mask_ff[BIT_CAP_A])
    else $error("Capture A enable cleared in waveform mode.");

  a_cap_b_clear_mode: assert property (
    wr_clr && wave_ff && mask_ff[BIT_CAP_B] |=> mask_ff[BIT_CAP_B])
    else $error("Capture B enable cleared in waveform mode.");

  a_trig_ovf_clear: assert property (
    wr_clr && wdata_ff[BIT_EXT_TRIG] && wdata_ff[BIT_OVERFLOW]
      |=> !mask_ff[BIT_EXT_TRIG] && !mask_ff[BIT_OVERFLOW])
    else $error("Trigger or overflow enable not cleared.");

  a_status_read_clear: assert property (
    s_status_read |=> status_ff == '0 ##0 s_axi_rdata_o[SRC_N-1:0] == $past(status_ff))
    else $error("Status read did not return and clear the flags.");

  a_mode_gates_events: assert property (
    wave_ff && !rd_status && (wr_state_ff == WR_IDLE) && !aw_hold_ff
      && status_ff[BIT_CAP_A] == 1'b0 |=> !status_ff[BIT_CAP_A])
    else $error("Capture event recorded in waveform mode.");

  a_irq_follows_flags: assert property (
    ##1 irq_o == |(status_ff & mask_ff))
    else $error("Interrupt line disagrees with flags and mask.");

  a_reserved_read_zero: assert property (
    rvalid_ff |-> s_axi_rdata_o[DATA_W-1:SRC_N] == '0)
    else $error("Reserved read bits are not zero.");

endmodule

// ===== bench/tb_timer_channel_irq_mask.sv
`timescale 1ns/1ns

module tb_timer_channel_irq_mask;
  import tci_pkg::*;

  logic              clk_i;
  logic              srst_i;
  tci_evt_t          evt;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, irq, wave;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0]        wstrb;
  logic [3:0]        strb_sel;
  logic [1:0]        bresp, rresp;
  int                n_fail;
  int                comparisons;
  logic [7:0]        exp_m;

  tci_irq_mask dut (
    .clk_i(clk_i), .srst_i(srst_i), .evt_i(evt),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .irq_o(irq), .wave_mode_o(wave)
  );

  ////////////////////////////////////////////////////////////////////////////
  // The clock toggles every half period of 5 ns.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every comparison is counted, and a mismatch is reported at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The verdict is printed in one place only, so the watchdog shares it.
  task automatic results();
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes are judged at the falling edge, where the inputs have settled,
  // so the next rising edge never races with the design's own registers.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hit;
    logic w_hit;
    logic got_b;
    @(posedge clk_i);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= strb_sel;
    bready  <= 1'b1;
    got_b = 1'b0;
    while (!got_b) begin
      @(negedge clk_i);
      aw_hit = awvalid && awready;
      w_hit  = wvalid && wready;
      got_b  = bvalid;
      if (got_b) begin
        chk({30'h0, bresp}, {30'h0, er});
      end
      @(posedge clk_i);
      if (aw_hit) begin
        awvalid <= 1'b0;
      end
      if (w_hit) begin
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
  endtask

  // A read holds rready from the start and checks data and response.
  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic got_r;
    @(posedge clk_i);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    got_r = 1'b0;
    while (!got_r) begin
      @(negedge clk_i);
      got_r = rvalid;
      if (got_r) begin
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
      end
      if (arvalid && arready) begin
        @(posedge clk_i);
        arvalid <= 1'b0;
      end else begin
        @(posedge clk_i);
      end
    end
    rready <= 1'b0;
  endtask

  // One cycle of event flags; outputs are looked at once it has been taken.
  task automatic pulse(input logic [7:0] v);
    @(posedge clk_i);
    evt <= tci_evt_t'(v);
    @(posedge clk_i);
    evt <= tci_evt_t'(8'h00);
    @(negedge clk_i);
  endtask

  task automatic do_reset();
    srst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // A hang costs a mismatch and ends the run through the usual verdict.
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence of register and event scenarios.
  initial begin
    n_fail = 0;
    comparisons = 0;
    srst_i = 1'b1;
    evt = tci_evt_t'(8'h00);
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    strb_sel = 4'hf;
    do_reset();
    @(negedge clk_i);
    chk({31'h0, irq}, 32'h0);
    axi_read(OFF_STATE, 32'h0, RESP_OKAY);
    // Set bits accumulate; written zeros and reserved bits change nothing.
    axi_write(OFF_SET, 32'h1, RESP_OKAY);
    axi_write(OFF_SET, 32'h10, RESP_OKAY);
    axi_read(OFF_STATE, 32'h11, RESP_OKAY);
    axi_write(OFF_SET, 32'hffffff00, RESP_OKAY);
    axi_read(OFF_STATE, 32'h11, RESP_OKAY);
    axi_write(OFF_SET, 32'hffffffff, RESP_OKAY);
    axi_read(OFF_STATE, 32'hff, RESP_OKAY);
    // Write-only places read zero and the state register ignores writes.
    axi_read(OFF_SET, 32'h0, RESP_OKAY);
    axi_read(OFF_CLEAR, 32'h0, RESP_OKAY);
    axi_write(OFF_STATE, 32'h0, RESP_OKAY);
    axi_read(OFF_STATE, 32'hff, RESP_OKAY);
    axi_write(OFF_CLEAR, 32'hffffff00, RESP_OKAY);
    axi_read(OFF_STATE, 32'hff, RESP_OKAY);
    // Each bit is cleared alone in both modes; mode-qualified bits hold
    // when the mode does not match.
    for (int m = 0; m < 2; m++) begin
      axi_write(OFF_MODE, m, RESP_OKAY);
      chk({31'h0, wave}, m);
      for (int i = 0; i < 8; i++) begin
        axi_write(OFF_SET, 32'hff, RESP_OKAY);
        axi_write(OFF_CLEAR, 32'h1 << i, RESP_OKAY);
        exp_m = 8'hff;
        if (!((CAPTURE_ONLY[i] && m == 1) || (WAVE_ONLY[i] && m == 0))) begin
          exp_m[i] = 1'b0;
        end
        axi_read(OFF_STATE, {24'h0, exp_m}, RESP_OKAY);
      end
    end
    // Leave only the compare-C source enabled, in waveform mode.
    axi_write(OFF_CLEAR, 32'hff, RESP_OKAY);
    axi_read(OFF_STATE, 32'h62, RESP_OKAY);
    axi_write(OFF_MODE, 32'h0, RESP_OKAY);
    axi_write(OFF_CLEAR, 32'hff, RESP_OKAY);
    axi_write(OFF_MODE, 32'h1, RESP_OKAY);
    axi_write(OFF_SET, 32'h10, RESP_OKAY);
    // A masked event flags status but raises no interrupt.
    pulse(8'h01);
    chk({31'h0, irq}, 32'h0);
    pulse(8'h10);
    chk({31'h0, irq}, 32'h1);
    axi_read(OFF_STATUS, 32'h11, RESP_OKAY);
    @(negedge clk_i);
    chk({31'h0, irq}, 32'h0);
    axi_read(OFF_STATUS, 32'h0, RESP_OKAY);
    // Mode gating keeps only the sources that belong to the mode.
    pulse(8'h6e);
    axi_read(OFF_STATUS, 32'h0c, RESP_OKAY);
    axi_write(OFF_MODE, 32'h0, RESP_OKAY);
    pulse(8'h6e);
    axi_read(OFF_STATUS, 32'h62, RESP_OKAY);
    // A written one clears its status flag and leaves the others standing.
    pulse(8'h81);
    axi_write(OFF_STATUS, 32'h01, RESP_OKAY);
    axi_read(OFF_STATUS, 32'h80, RESP_OKAY);
    // Without byte lane 0 a set write carries no defined bits.
    strb_sel = 4'he;
    axi_write(OFF_SET, 32'hff, RESP_OKAY);
    strb_sel = 4'hf;
    axi_read(OFF_STATE, 32'h10, RESP_OKAY);
    // An unmapped place answers with an error and has no effect.
    axi_write(8'h3c, 32'hff, RESP_SLVERR);
    axi_read(8'h3c, 32'h0, RESP_SLVERR);
    axi_read(OFF_STATE, 32'h10, RESP_OKAY);
    // A second reset in mid-run drops the mask again.
    do_reset();
    axi_read(OFF_STATE, 32'h0, RESP_OKAY);
    results();
  end

endmodule
